// File: core/dpls_pkg.sv
// Constants, types and timing counts for the D-PHY lane mode sequencer
// Overview of operation
// - Lanes alternate between low-power signalling and high-speed bursts by a fixed handshake.
// - Burst entry walks LP-11, LP-01, LP-00 on the lane.
// - Leaving high speed always returns the lane to LP-11 stop.
// - Clock keeps toggling 60 ns plus 52 UI after data trail ends.
// - Clock toggles at least 8 UI before data leaves low power.
// - Clock lane LP-00 before HS-0 lasts 38 to 95 ns.
// - Clock lane holds HS-0 at least 60 ns after last clock bit.
// - Clock prepare plus clock zero lasts at least 300 ns.
// - Data lane LP-00 before HS-0 lasts 40 ns+4 UI to 85 ns+6 UI.
// - Data prepare plus data zero lasts at least 145 ns plus 10 UI.
// - Data trail lasts at least max(n*8 UI, 60 ns + n*4 UI).
// - Every driven low-power state other than the LP-00 prepare lasts at least 50 ns.
// - Clock and data settle timers are configurable from 40 to 2590 ns.
`default_nettype none
package dpls_pkg;

	localparam int unsigned CLK_PS = 4000;
	localparam int unsigned UI_PS = 1000;
	localparam int unsigned N_TRAIL = 1;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_D = 8;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned SET_W = 12;

	localparam int unsigned T_LPX_NS = 50;
	localparam int unsigned T_CLK_PREP_MIN_NS = 38;
	localparam int unsigned T_CLK_PREP_MAX_NS = 95;
	localparam int unsigned T_CLK_PZ_NS = 300;
	localparam int unsigned T_CLK_TRAIL_NS = 60;
	localparam int unsigned T_CLK_POST_NS = 60;
	localparam int unsigned T_CLK_POST_UI = 52;
	localparam int unsigned T_CLK_PRE_UI = 8;
	localparam int unsigned T_HS_PREP_MIN_NS = 40;
	localparam int unsigned T_HS_PREP_MIN_UI = 4;
	localparam int unsigned T_HS_PREP_MAX_NS = 85;
	localparam int unsigned T_HS_PREP_MAX_UI = 6;
	localparam int unsigned T_HS_PZ_NS = 145;
	localparam int unsigned T_HS_PZ_UI = 10;
	localparam int unsigned T_HS_TRAIL_A_UI = 8;
	localparam int unsigned T_HS_TRAIL_NS = 60;
	localparam int unsigned T_HS_TRAIL_B_UI = 4;
	localparam int unsigned SETTLE_MIN_NS = 40;
	localparam int unsigned SETTLE_MAX_NS = 2590;

	// Minimum times rounded up to whole cycles
	localparam int unsigned LPX_PS = T_LPX_NS * 1000;
	localparam int unsigned CLK_PREP_PS = T_CLK_PREP_MIN_NS * 1000;
	localparam int unsigned CLK_PZ_PS = T_CLK_PZ_NS * 1000;
	localparam int unsigned CLK_TRAIL_PS = T_CLK_TRAIL_NS * 1000;
	localparam int unsigned CLK_POST_PS = T_CLK_POST_NS * 1000 + T_CLK_POST_UI * UI_PS;
	localparam int unsigned CLK_PRE_PS = T_CLK_PRE_UI * UI_PS;
	localparam int unsigned HS_PREP_PS = T_HS_PREP_MIN_NS * 1000 + T_HS_PREP_MIN_UI * UI_PS;
	localparam int unsigned HS_PZ_PS = T_HS_PZ_NS * 1000 + T_HS_PZ_UI * UI_PS;
	localparam int unsigned HS_TRAIL_A_PS = N_TRAIL * T_HS_TRAIL_A_UI * UI_PS;
	localparam int unsigned HS_TRAIL_B_PS = T_HS_TRAIL_NS * 1000 + N_TRAIL * T_HS_TRAIL_B_UI * UI_PS;
	localparam int unsigned HS_TRAIL_PS =
		(HS_TRAIL_A_PS > HS_TRAIL_B_PS) ? HS_TRAIL_A_PS : HS_TRAIL_B_PS;

	localparam logic [CNT_W-1:0] LPX_CYC = CNT_W'((LPX_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CLK_PREP_CYC = CNT_W'((CLK_PREP_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CLK_ZERO_CYC =
		CNT_W'((CLK_PZ_PS + CLK_PS - 1) / CLK_PS - (CLK_PREP_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CLK_PRE_CYC = CNT_W'((CLK_PRE_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CLK_POST_CYC = CNT_W'((CLK_POST_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] CLK_TRAIL_CYC = CNT_W'((CLK_TRAIL_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] HS_PREP_CYC = CNT_W'((HS_PREP_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] HS_ZERO_CYC =
		CNT_W'((HS_PZ_PS + CLK_PS - 1) / CLK_PS - (HS_PREP_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] HS_TRAIL_CYC = CNT_W'((HS_TRAIL_PS + CLK_PS - 1) / CLK_PS);
	// Longest prepare rounded down; the chosen counts must not pass them
	localparam logic [CNT_W-1:0] CLK_PREP_MAX_CYC = CNT_W'(T_CLK_PREP_MAX_NS * 1000 / CLK_PS);
	localparam logic [CNT_W-1:0] HS_PREP_MAX_CYC =
		CNT_W'((T_HS_PREP_MAX_NS * 1000 + T_HS_PREP_MAX_UI * UI_PS) / CLK_PS);

	localparam logic [SET_W-1:0] SET_MIN = SET_W'(SETTLE_MIN_NS);
	localparam logic [SET_W-1:0] SET_MAX = SET_W'(SETTLE_MAX_NS);
	localparam logic [SET_W-1:0] NS_PER_CLK = SET_W'(CLK_PS / 1000);
	localparam logic [DATA_W-1:0] SYNC_BYTE = 8'hb8;

	typedef enum logic [1:0] {
		LP00 = 2'h0,
		LP01 = 2'h1,
		LP10 = 2'h2,
		LP11 = 2'h3
	} dpls_lp_t;

	// Per-lane line control: low-power level, HS driver on, HS forced to zero
	typedef struct packed {
		dpls_lp_t lp;
		logic hs_en;
		logic hs_zero;
	} dpls_lane_t;

	typedef enum logic [3:0] {
		ST_STOP,
		ST_CLK_LP01,
		ST_CLK_PREP,
		ST_CLK_ZERO,
		ST_CLK_PRE,
		ST_DAT_LP01,
		ST_DAT_PREP,
		ST_DAT_ZERO,
		ST_DAT_HS,
		ST_DAT_TRAIL,
		ST_CLK_POST,
		ST_CLK_TRAIL
	} dpls_state_t;

endpackage
`default_nettype wire

// File: core/dpls_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dpls_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap by compare so any depth works, not only powers of two
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // dpls_fifo
`default_nettype wire

// File: core/dpls_lane_seq.sv
// D-PHY clock and data lane mode sequencer, transmit side
`timescale 1ns/1ns
`default_nettype none
module dpls_lane_seq (
	// Core clock and reset
	input wire logic clk,
	input wire logic resetn,
	// High-speed byte clock and its reset
	input wire logic link_clk,
	input wire logic link_resetn,
	// Payload stream in
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [dpls_pkg::DATA_W-1:0] in_data,
	// Settle timer set-up for the receiving end, in ns in and core cycles out
	input wire logic [dpls_pkg::SET_W-1:0] clk_settle_ns,
	input wire logic [dpls_pkg::SET_W-1:0] hs_settle_ns,
	output logic [dpls_pkg::SET_W-1:0] clk_settle_cyc_q,
	output logic [dpls_pkg::SET_W-1:0] hs_settle_cyc_q,
	// Lane line states, core domain
	output dpls_pkg::dpls_lane_t clk_lane_q,
	output dpls_pkg::dpls_lane_t dat_lane_q,
	output dpls_pkg::dpls_state_t state_q,
	output logic busy,
	// High-speed lane drive, link domain
	output logic hs_clk_q,
	output logic [dpls_pkg::DATA_W-1:0] hs_byte_q,
	output logic hs_byte_vld_q,
	output logic hs_trail_q
);
	dpls_pkg::dpls_state_t state_d;
	logic [dpls_pkg::CNT_W-1:0] cnt_q;
	logic [dpls_pkg::CNT_W-1:0] dur;
	logic cnt_done;

	logic f_valid;
	logic f_ready;
	logic [dpls_pkg::DATA_W-1:0] f_data;

	// Core to link word handshake
	logic req_q;
	logic [dpls_pkg::DATA_W-1:0] xfer_q;
	logic sync_sent_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic xfer_busy;
	// Link side
	logic req_s1_q;
	logic req_s2_q;
	logic ack_q;
	logic run_s1_q;
	logic run_s2_q;
	logic trail_s1_q;
	logic trail_s2_q;
	logic clk_run_q;
	logic dat_trail_q;

	dpls_fifo #(
		.WIDTH(dpls_pkg::DATA_W),
		.DEPTH(dpls_pkg::FIFO_D)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	assign cnt_done = (cnt_q == '0);
	assign xfer_busy = (req_q != ack_s2_q);
	assign busy = (state_q != dpls_pkg::ST_STOP);
	// Pop only once the previous word has been taken by the link side
	assign f_ready = (state_q == dpls_pkg::ST_DAT_HS) && sync_sent_q && !xfer_busy;

	// Sequence of line states for one burst
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			dpls_pkg::ST_STOP: begin
				if (cnt_done && f_valid) begin
					state_d = dpls_pkg::ST_CLK_LP01;
				end
			end
			dpls_pkg::ST_CLK_LP01: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_CLK_PREP;
				end
			end
			dpls_pkg::ST_CLK_PREP: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_CLK_ZERO;
				end
			end
			dpls_pkg::ST_CLK_ZERO: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_CLK_PRE;
				end
			end
			dpls_pkg::ST_CLK_PRE: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_DAT_LP01;
				end
			end
			dpls_pkg::ST_DAT_LP01: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_DAT_PREP;
				end
			end
			dpls_pkg::ST_DAT_PREP: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_DAT_ZERO;
				end
			end
			dpls_pkg::ST_DAT_ZERO: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_DAT_HS;
				end
			end
			dpls_pkg::ST_DAT_HS: begin
				// Burst ends when the buffer runs dry and the last word is across
				if (sync_sent_q && !f_valid && !xfer_busy) begin
					state_d = dpls_pkg::ST_DAT_TRAIL;
				end
			end
			dpls_pkg::ST_DAT_TRAIL: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_CLK_POST;
				end
			end
			dpls_pkg::ST_CLK_POST: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_CLK_TRAIL;
				end
			end
			dpls_pkg::ST_CLK_TRAIL: begin
				if (cnt_done) begin
					state_d = dpls_pkg::ST_STOP;
				end
			end
			default: begin
				state_d = dpls_pkg::ST_STOP;
			end
		endcase
	end

	// Length of each timed phase, rounded up at elaboration
	always_comb begin
		unique case (state_d)
			dpls_pkg::ST_STOP: dur = dpls_pkg::LPX_CYC;
			dpls_pkg::ST_CLK_LP01: dur = dpls_pkg::LPX_CYC;
			dpls_pkg::ST_CLK_PREP: dur = dpls_pkg::CLK_PREP_CYC;
			dpls_pkg::ST_CLK_ZERO: dur = dpls_pkg::CLK_ZERO_CYC;
			dpls_pkg::ST_CLK_PRE: dur = dpls_pkg::CLK_PRE_CYC;
			dpls_pkg::ST_DAT_LP01: dur = dpls_pkg::LPX_CYC;
			dpls_pkg::ST_DAT_PREP: dur = dpls_pkg::HS_PREP_CYC;
			dpls_pkg::ST_DAT_ZERO: dur = dpls_pkg::HS_ZERO_CYC;
			dpls_pkg::ST_DAT_HS: dur = '0;
			dpls_pkg::ST_DAT_TRAIL: dur = dpls_pkg::HS_TRAIL_CYC;
			dpls_pkg::ST_CLK_POST: dur = dpls_pkg::CLK_POST_CYC;
			dpls_pkg::ST_CLK_TRAIL: dur = dpls_pkg::CLK_TRAIL_CYC;
			default: dur = dpls_pkg::LPX_CYC;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= dpls_pkg::ST_STOP;
		end else begin
			state_q <= state_d;
		end
	end

	// Phase timer: loads on every state change, counts down to zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= dpls_pkg::LPX_CYC - 1'b1;
		end else if (state_d != state_q) begin
			cnt_q <= (dur == '0) ? '0 : dur - 1'b1;
		end else if (!cnt_done) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Clock lane line state per phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clk_lane_q <= '{lp: dpls_pkg::LP11, hs_en: 1'b0, hs_zero: 1'b0};
		end else begin
			unique case (state_d)
				dpls_pkg::ST_CLK_LP01: begin
					clk_lane_q <= '{lp: dpls_pkg::LP01, hs_en: 1'b0, hs_zero: 1'b0};
				end
				dpls_pkg::ST_CLK_PREP: begin
					clk_lane_q <= '{lp: dpls_pkg::LP00, hs_en: 1'b0, hs_zero: 1'b0};
				end
				dpls_pkg::ST_CLK_ZERO, dpls_pkg::ST_CLK_TRAIL: begin
					clk_lane_q <= '{lp: dpls_pkg::LP00, hs_en: 1'b1, hs_zero: 1'b1};
				end
				dpls_pkg::ST_CLK_PRE, dpls_pkg::ST_DAT_LP01, dpls_pkg::ST_DAT_PREP,
				dpls_pkg::ST_DAT_ZERO, dpls_pkg::ST_DAT_HS, dpls_pkg::ST_DAT_TRAIL,
				dpls_pkg::ST_CLK_POST: begin
					clk_lane_q <= '{lp: dpls_pkg::LP00, hs_en: 1'b1, hs_zero: 1'b0};
				end
				default: begin
					clk_lane_q <= '{lp: dpls_pkg::LP11, hs_en: 1'b0, hs_zero: 1'b0};
				end
			endcase
		end
	end

	// Data lane line state per phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dat_lane_q <= '{lp: dpls_pkg::LP11, hs_en: 1'b0, hs_zero: 1'b0};
		end else begin
			unique case (state_d)
				dpls_pkg::ST_DAT_LP01: begin
					dat_lane_q <= '{lp: dpls_pkg::LP01, hs_en: 1'b0, hs_zero: 1'b0};
				end
				dpls_pkg::ST_DAT_PREP: begin
					dat_lane_q <= '{lp: dpls_pkg::LP00, hs_en: 1'b0, hs_zero: 1'b0};
				end
				dpls_pkg::ST_DAT_ZERO: begin
					dat_lane_q <= '{lp: dpls_pkg::LP00, hs_en: 1'b1, hs_zero: 1'b1};
				end
				dpls_pkg::ST_DAT_HS, dpls_pkg::ST_DAT_TRAIL: begin
					dat_lane_q <= '{lp: dpls_pkg::LP00, hs_en: 1'b1, hs_zero: 1'b0};
				end
				default: begin
					dat_lane_q <= '{lp: dpls_pkg::LP11, hs_en: 1'b0, hs_zero: 1'b0};
				end
			endcase
		end
	end

	// Level controls handed to the link domain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clk_run_q <= 1'b0;
			dat_trail_q <= 1'b0;
		end else begin
			clk_run_q <= (state_d == dpls_pkg::ST_CLK_PRE) || (state_d == dpls_pkg::ST_DAT_LP01)
				|| (state_d == dpls_pkg::ST_DAT_PREP) || (state_d == dpls_pkg::ST_DAT_ZERO)
				|| (state_d == dpls_pkg::ST_DAT_HS) || (state_d == dpls_pkg::ST_DAT_TRAIL)
				|| (state_d == dpls_pkg::ST_CLK_POST);
			dat_trail_q <= (state_d == dpls_pkg::ST_DAT_TRAIL);
		end
	end

	// Word launch: sync byte first, then payload; toggle request per word
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_q <= 1'b0;
			xfer_q <= '0;
			sync_sent_q <= 1'b0;
		end else if (state_q != dpls_pkg::ST_DAT_HS) begin
			sync_sent_q <= 1'b0;
		end else if (!xfer_busy) begin
			if (!sync_sent_q) begin
				xfer_q <= dpls_pkg::SYNC_BYTE;
				req_q <= !req_q;
				sync_sent_q <= 1'b1;
			end else if (f_valid) begin
				xfer_q <= f_data;
				req_q <= !req_q;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	// Settle timers clamped to the allowed range, in core cycles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clk_settle_cyc_q <= '0;
			hs_settle_cyc_q <= '0;
		end else begin
			clk_settle_cyc_q <= ns_to_cyc(clk_settle_ns);
			hs_settle_cyc_q <= ns_to_cyc(hs_settle_ns);
		end
	end

	function automatic logic [dpls_pkg::SET_W-1:0] ns_to_cyc(
		input logic [dpls_pkg::SET_W-1:0] ns
	);
		logic [dpls_pkg::SET_W-1:0] c;
		c = ns;
		if (c < dpls_pkg::SET_MIN) begin
			c = dpls_pkg::SET_MIN;
		end
		if (c > dpls_pkg::SET_MAX) begin
			c = dpls_pkg::SET_MAX;
		end
		// Rounded up so the window is never shorter than the clamped request
		return (c + dpls_pkg::NS_PER_CLK - 1'b1) / dpls_pkg::NS_PER_CLK;
	endfunction

	// Link domain: synchronisers for request and the two levels
	always_ff @(posedge link_clk or negedge link_resetn) begin
		if (!link_resetn) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			run_s1_q <= 1'b0;
			run_s2_q <= 1'b0;
			trail_s1_q <= 1'b0;
			trail_s2_q <= 1'b0;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			run_s1_q <= clk_run_q;
			run_s2_q <= run_s1_q;
			trail_s1_q <= dat_trail_q;
			trail_s2_q <= trail_s1_q;
		end
	end

	// Word capture; xfer_q is stable while the request is open
	always_ff @(posedge link_clk or negedge link_resetn) begin
		if (!link_resetn) begin
			ack_q <= 1'b0;
			hs_byte_q <= '0;
			hs_byte_vld_q <= 1'b0;
		end else begin
			hs_byte_vld_q <= (req_s2_q != ack_q);
			if (req_s2_q != ack_q) begin
				hs_byte_q <= xfer_q;
				ack_q <= req_s2_q;
			end
		end
	end

	// High-speed clock toggles only while the core asks for it
	always_ff @(posedge link_clk or negedge link_resetn) begin
		if (!link_resetn) begin
			hs_clk_q <= 1'b0;
			hs_trail_q <= 1'b0;
		end else begin
			hs_clk_q <= run_s2_q ? !hs_clk_q : 1'b0;
			hs_trail_q <= trail_s2_q;
		end
	end
endmodule // dpls_lane_seq
`default_nettype wire

// File: tb/dpls_lane_seq_asserts.sv
// Phase timing checker for the lane mode sequencer
`timescale 1ns/1ns
`default_nettype none
module dpls_lane_seq_asserts (
	// Clocks and resets
	input wire logic clk,
	input wire logic resetn,
	input wire logic link_clk,
	input wire logic link_resetn,
	// Settle set-up
	input wire logic [dpls_pkg::SET_W-1:0] clk_settle_ns,
	input wire logic [dpls_pkg::SET_W-1:0] clk_settle_cyc_q,
	// Lanes and state
	input wire dpls_pkg::dpls_lane_t clk_lane_q,
	input wire dpls_pkg::dpls_lane_t dat_lane_q,
	input wire dpls_pkg::dpls_state_t state_q,
	input wire logic hs_byte_vld_q
);
	dpls_pkg::dpls_state_t last_q;
	logic [7:0] dwell_q;
	logic up_q;
	// Saturates so a long idle stop never wraps below the minimum
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			last_q <= dpls_pkg::ST_STOP;
			dwell_q <= 8'h00;
		end else begin
			last_q <= state_q;
			dwell_q <= (state_q != last_q) ? 8'h01 : (dwell_q == 8'hff) ? dwell_q : dwell_q + 8'h01;
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) up_q <= 1'b0;
		else up_q <= 1'b1;
	end
	function automatic logic [11:0] to_cyc(input logic [11:0] ns);
		logic [11:0] c;
		c = (ns < 12'h028) ? 12'h028 : (ns > 12'ha1e) ? 12'ha1e : ns;
		return (c + 12'h003) >> 2;
	endfunction
	property dwell_p(dpls_pkg::dpls_state_t s, int n);
		@(posedge clk) disable iff (!resetn) (state_q != last_q && last_q == s) |-> dwell_q == n;
	endproperty
	sequence clk_prep_s;
		clk_lane_q.lp == dpls_pkg::LP00 && !clk_lane_q.hs_en;
	endsequence
	sequence clk_zero_s;
		clk_lane_q.hs_en && clk_lane_q.hs_zero;
	endsequence
	sequence dat_prep_s;
		dat_lane_q.lp == dpls_pkg::LP00 && !dat_lane_q.hs_en;
	endsequence
	sequence dat_zero_s;
		dat_lane_q.hs_en && dat_lane_q.hs_zero;
	endsequence
	stop_gap_a: assert property (@(posedge clk) disable iff (!resetn)
		(state_q != last_q && last_q == dpls_pkg::ST_STOP) |-> dwell_q >= 8'h0d) else $error("stop short");
	clk_prep_len_a: assert property (dwell_p(dpls_pkg::ST_CLK_PREP, 8'h0a)) else $error("clk prep");
	clk_zero_len_a: assert property (dwell_p(dpls_pkg::ST_CLK_ZERO, 8'h41)) else $error("clk zero");
	clk_pre_len_a: assert property (dwell_p(dpls_pkg::ST_CLK_PRE, 8'h02)) else $error("clk pre");
	dat_prep_len_a: assert property (dwell_p(dpls_pkg::ST_DAT_PREP, 8'h0b)) else $error("hs prep");
	dat_zero_len_a: assert property (dwell_p(dpls_pkg::ST_DAT_ZERO, 8'h1c)) else $error("hs zero");
	dat_trail_len_a: assert property (dwell_p(dpls_pkg::ST_DAT_TRAIL, 8'h10)) else $error("trail");
	clk_post_len_a: assert property (dwell_p(dpls_pkg::ST_CLK_POST, 8'h1c)) else $error("post");
	clk_trail_len_a: assert property (dwell_p(dpls_pkg::ST_CLK_TRAIL, 8'h0f)) else $error("ctrail");
	clk_entry_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(clk_lane_q.lp == dpls_pkg::LP01) |-> ##13 clk_prep_s ##10 clk_zero_s) else $error("clk entry");
	dat_entry_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(dat_lane_q.lp == dpls_pkg::LP01) |-> ##13 dat_prep_s ##11 dat_zero_s) else $error("hs entry");
	clk_exit_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(clk_lane_q.hs_en) |-> clk_lane_q.lp == dpls_pkg::LP11 && state_q == dpls_pkg::ST_STOP)
		else $error("clk exit");
	dat_exit_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(dat_lane_q.hs_en) |-> dat_lane_q.lp == dpls_pkg::LP11 && state_q == dpls_pkg::ST_CLK_POST)
		else $error("data exit");
	settle_map_a: assert property (@(posedge clk) disable iff (!resetn)
		up_q |-> clk_settle_cyc_q == to_cyc($past(clk_settle_ns))) else $error("settle count");
	vld_pulse_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
		hs_byte_vld_q |=> !hs_byte_vld_q) else $error("byte pulse");
endmodule // dpls_lane_seq_asserts
bind dpls_lane_seq dpls_lane_seq_asserts i_chk (.clk, .resetn, .link_clk, .link_resetn,
	.clk_settle_ns, .clk_settle_cyc_q, .clk_lane_q, .dat_lane_q, .state_q, .hs_byte_vld_q);
`default_nettype wire

// File: tb/dpls_rx_model.sv
// Far-end receiver model: settle windows, sync hunt, payload capture
`timescale 1ns/1ns
`default_nettype none
module dpls_rx_model (
	// Clocks
	input wire logic clk,
	input wire logic link_clk,
	// Lanes and HS data
	input wire dpls_pkg::dpls_lane_t clk_lane_q,
	input wire dpls_pkg::dpls_lane_t dat_lane_q,
	input wire logic hs_clk_q,
	input wire logic [7:0] hs_byte_q,
	input wire logic hs_byte_vld_q,
	// Settle windows in core cycles
	input wire logic [11:0] clk_settle_cyc_q,
	input wire logic [11:0] hs_settle_cyc_q
);
	logic [7:0] got_q[$];
	int clk_win;
	int dat_win;
	int clk_edges;
	int bad_sync;
	bit hunt;
	// Windows open at prepare start and close when the lane is back in low power
	always @(posedge clk) begin
		clk_win = (clk_lane_q.lp != dpls_pkg::LP00 && !clk_lane_q.hs_en) ? 0 : clk_win + 1;
		dat_win = (dat_lane_q.lp != dpls_pkg::LP00 && !dat_lane_q.hs_en) ? 0 : dat_win + 1;
		if (dat_win == 0) hunt = 1'b1;
	end
	always @(posedge hs_clk_q) if (clk_win >= clk_settle_cyc_q) clk_edges++;
	// Bytes inside the settle window are lost, as on a real receiver
	always @(posedge link_clk) if (hs_byte_vld_q && dat_win >= hs_settle_cyc_q) begin
		if (hunt) begin
			if (hs_byte_q !== dpls_pkg::SYNC_BYTE) bad_sync++;
			hunt = 1'b0;
		end else got_q.push_back(hs_byte_q);
	end
endmodule // dpls_rx_model
`default_nettype wire

// File: tb/dpls_lane_seq_tb.sv
// Self-checking bench for the lane mode sequencer
`timescale 1ns/1ns
`default_nettype none
module dpls_lane_seq_tb;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic resetn = 1'b1;
	logic in_valid = 1'b0;
	logic [7:0] in_data = 8'h00;
	logic [11:0] clk_settle_ns = 12'h0c8;
	logic [11:0] hs_settle_ns = 12'h064;
	logic in_ready, busy, hs_clk_q, hs_byte_vld_q, hs_trail_q;
	logic [11:0] clk_settle_cyc_q, hs_settle_cyc_q;
	logic [7:0] hs_byte_q;
	dpls_pkg::dpls_lane_t clk_lane_q, dat_lane_q;
	dpls_pkg::dpls_state_t state_q;
	dpls_pkg::dpls_state_t prev = dpls_pkg::ST_STOP;
	int num_errors, checks, cyc, run, trails;
	int dur[16];
	logic [7:0] sent[$];
	logic [11:0] s_ns[6] = '{12'h000, 12'h029, 12'h05f, 12'h12c, 12'ha1e, 12'hfa0};
	logic [11:0] s_cyc[6] = '{12'h00a, 12'h00b, 12'h018, 12'h04b, 12'h288, 12'h288};
	dpls_pkg::dpls_state_t d_st[10] = '{dpls_pkg::ST_CLK_LP01, dpls_pkg::ST_CLK_PREP,
		dpls_pkg::ST_CLK_ZERO, dpls_pkg::ST_CLK_PRE, dpls_pkg::ST_DAT_LP01, dpls_pkg::ST_DAT_PREP,
		dpls_pkg::ST_DAT_ZERO, dpls_pkg::ST_DAT_TRAIL, dpls_pkg::ST_CLK_POST, dpls_pkg::ST_CLK_TRAIL};
	// Whole cycles of 4 ns, rounded up from each minimum
	int d_exp[10] = '{(50+3)/4, (38+3)/4, (300+3)/4-10, (8+3)/4, (50+3)/4, (44+3)/4,
		(155+3)/4-11, (64+3)/4, (112+3)/4, (60+3)/4};

	always #2 clk = ~clk;
	always begin
		#8 link_clk = ~link_clk;
		#7 link_clk = ~link_clk;
	end

	dpls_lane_seq i_dut (.clk, .resetn, .link_clk, .link_resetn(resetn), .in_valid, .in_ready,
		.in_data, .clk_settle_ns, .hs_settle_ns, .clk_settle_cyc_q, .hs_settle_cyc_q, .clk_lane_q,
		.dat_lane_q, .state_q, .busy, .hs_clk_q, .hs_byte_q, .hs_byte_vld_q, .hs_trail_q);
	dpls_rx_model i_rx (.clk, .link_clk, .clk_lane_q, .dat_lane_q, .hs_clk_q, .hs_byte_q,
		.hs_byte_vld_q, .clk_settle_cyc_q, .hs_settle_cyc_q);

	task automatic check(input logic ok, input string what);
		checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Holds valid up between bytes; caller lowers it after the last
	// Ready is looked at mid-cycle, where it stands until the taking edge
	task automatic push(input logic [7:0] b);
		in_valid = 1'b1;
		in_data = b;
		sent.push_back(b);
		while (in_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
	endtask
	task automatic burst_done();
		in_valid = 1'b0;
		wait (busy === 1'b1);
		wait (busy === 1'b0);
		// Two more edges so the phase monitor has closed the last clock trail
		repeat (2) @(negedge clk);
		check(i_rx.got_q.size() == sent.size() && i_rx.bad_sync == 0, "burst size or sync");
		foreach (sent[i]) check(i_rx.got_q[i] === sent[i], "payload order");
	endtask
	task automatic idle_chk();
		check(clk_lane_q === 4'hc && dat_lane_q === 4'hc && state_q === dpls_pkg::ST_STOP &&
			in_ready === 1'b1 && hs_clk_q === 1'b0 && hs_byte_vld_q === 1'b0, "idle lanes");
	endtask

	// Phase lengths seen on the state port; timeout guard
	always @(posedge clk) begin
		cyc++;
		if (hs_trail_q === 1'b1) trails++;
		if (state_q === prev) run++;
		else begin
			dur[prev] = run;
			run = 1;
		end
		prev = state_q;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		// A level set at time zero gives no edge, so reset is dropped here
		@(negedge clk);
		resetn = 1'b0;
		repeat (3) @(negedge clk);
		idle_chk();
		resetn = 1'b1;
		for (int i = 0; i < 6; i++) begin
			clk_settle_ns = s_ns[i];
			hs_settle_ns = s_ns[i];
			repeat (2) @(negedge clk);
			check(clk_settle_cyc_q === s_cyc[i] && hs_settle_cyc_q === s_cyc[i], "settle");
		end
		clk_settle_ns = 12'h0c8;
		hs_settle_ns = 12'h064;
		repeat (20) @(negedge clk);
		push(8'h5a);
		burst_done();
		for (int i = 0; i < 10; i++) check(dur[d_st[i]] == d_exp[i], "phase length");
		check(i_rx.clk_edges > 0 && trails > 0, "clock or trail missing");
		for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
		check(in_ready === 1'b0, "fifo full not refused");
		push(8'h18);
		burst_done();
		push(8'h77);
		in_valid = 1'b0;
		wait (state_q === dpls_pkg::ST_DAT_ZERO);
		@(negedge clk);
		resetn = 1'b0;
		@(negedge clk);
		idle_chk();
		repeat (3) @(negedge link_clk);
		@(negedge clk);
		resetn = 1'b1;
		sent.delete();
		i_rx.got_q.delete();
		repeat (20) @(negedge clk);
		push(8'h33);
		burst_done();
		idle_chk();
		stop_test();
	end
endmodule // dpls_lane_seq_tb
`default_nettype wire
